// File: include/clk_sel_pkg.sv
// Purpose: Shared constants for the start-up clock selection block.
// Assumes: 32-bit APB register access, one word per register.
// Notes:   Clock sources are given to the block as one-cycle tick enables.
package clk_sel_pkg;
  // Register byte offsets.
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_DIV    = 8'h08;
  localparam logic [7:0] OFS_TIMER  = 8'h0C;
  // Control register fields.
  localparam int CTRL_FREQ_LSB = 0;   // int_freq_sel bits 2:0
  localparam int CTRL_SRC_LSB  = 4;   // run-time source select 1:0
  localparam int CTRL_IDLE     = 8;   // write 1 to enter idle
  // Divider register fields.
  localparam int DIV_PLL_LSB   = 0;   // PLL multiplier select 1:0
  localparam int DIV_POST_LSB  = 4;   // postscaler select 2:0
  // Reset values.
  localparam logic [2:0] FREQ_RESET = 3'h0;
  localparam logic [1:0] PLL_RESET  = 2'h0;
  localparam logic [2:0] POST_RESET = 3'h0;
  // Frequency-select codes.
  localparam logic [2:0] FREQ_1MHZ  = 3'h4;
  localparam logic [2:0] FREQ_4MHZ  = 3'h6;
  localparam logic [2:0] FREQ_8MHZ  = 3'h7;
  // Primary oscillator modes.
  typedef enum logic [2:0] {
    OSC_LOW_POWER_CRYSTAL  = 3'b000,
    OSC_STANDARD_CRYSTAL   = 3'b001,
    OSC_HIGH_SPEED_CRYSTAL = 3'b010,
    OSC_EXT_CLOCK          = 3'b011,
    OSC_EXT_RC             = 3'b100
  } osc_mode_e;
  // Run-time system clock sources.
  typedef enum logic [1:0] {
    SRC_PRIMARY  = 2'b00,
    SRC_INTERNAL = 2'b01,
    SRC_LOW_FREQ = 2'b10,
    SRC_PLL      = 2'b11
  } clk_src_e;
  // Crystal start-up timer length in primary clock periods.
  localparam int XTAL_STARTUP_PERIODS = 1024;
  // Clock periods per instruction cycle.
  localparam int PERIODS_PER_INSTR = 4;
endpackage : clk_sel_pkg

// File: core/tick_divider.sv
// Purpose: Divides a tick enable by a programmable power of two.
// Assumes: Input ticks are one-cycle pulses on clk.
// Notes:   Shift 0 passes the ticks straight through.
`timescale 1ns/100ps
module tick_divider #(
  parameter int CW = 8
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         reset_n,
  // Ticks
  input  wire logic         tickIn,
  input  wire logic [2:0]   shift,
  output logic              tickOut
);
  logic [CW-1:0] cnt_q;
  logic [CW-1:0] mask;

  // Mask of counter bits that must all be set for an output tick.
  assign mask    = CW'((1 << shift) - 1);
  assign tickOut = tickIn && ((cnt_q & mask) == mask);

  // Free count of incoming ticks.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_q <= '0;
    end else if (tickIn) begin
      cnt_q <= cnt_q + CW'(1);
    end
  end
endmodule : tick_divider

// File: core/clock_select.sv
// Summary of operation
// - Two-speed start only when enable strap set.
// - Run from internal RC until timer expires.
// - Timer wait only in crystal modes.
// - Three-bit field steps internal RC frequency.
// - Software switches clock source without reset.
// - Software selects postscaler; PLL multiplier is stored and read back only.
// - Idle stops core, peripherals keep running.
// - Enabled peripheral interrupt ends idle.
//
// Purpose: Start-up and run-time system clock selection with idle control.
// Assumes: Each oscillator arrives as a one-cycle tick enable on clk.
// Notes:   Outputs are tick enables; the core counts four per instruction.
`timescale 1ns/100ps
module clock_select #(
  parameter int STARTUP_PERIODS = clk_sel_pkg::XTAL_STARTUP_PERIODS
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        reset_n,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Configuration straps
  input  wire logic        two_speed_start_enable,
  input  wire logic [2:0]  oscMode,
  // Oscillator ticks
  input  wire logic        primaryTick,
  input  wire logic        intRc8MhzTick,
  input  wire logic        lowFreqTick,
  input  wire logic        pllTick,
  // Interrupt wake
  input  wire logic        periphIrq,
  input  wire logic        periphIrqEn,
  // Clock enables out
  output logic             sysClkTick,
  output logic             periphClkTick,
  output logic             instrTick,
  output logic             coreRun
);
  typedef enum logic [1:0] {
    ST_STARTUP = 2'b00,
    ST_WAITXT  = 2'b01,
    ST_RUN     = 2'b10
  } boot_e;

  boot_e        state_q;
  logic         strapTaken_q;
  logic [2:0]   freq_q;
  logic [1:0]   src_q;
  logic [1:0]   pll_q;
  logic [2:0]   post_q;
  logic         idle_q;
  logic [15:0]  timer_q;
  logic [1:0]   phase_q;
  logic         timerDone;
  logic         isCrystal;
  logic         wr;
  logic         rd;
  logic         rcTick;
  logic         pllSel;
  logic         rawTick;
  logic [2:0]   rcShift;

  // Writes land at the access edge; read data is loaded at the setup edge, so it
  // already stands in the output register when the master samples it in access.
  assign wr = psel && penable && pwrite;
  assign rd = psel && !penable && !pwrite;
  assign pready  = 1'b1;
  assign pslverr = 1'b0;

  // Internal RC frequency as a divide of the 8 MHz tick; below 1 MHz runs slowest.
  function automatic logic [2:0] rcDivFor(input logic [2:0] f);
    unique case (f)
      clk_sel_pkg::FREQ_8MHZ: rcDivFor = 3'h0;
      clk_sel_pkg::FREQ_4MHZ: rcDivFor = 3'h1;
      clk_sel_pkg::FREQ_1MHZ: rcDivFor = 3'h3;
      default:                rcDivFor = 3'h7;
    endcase
  endfunction : rcDivFor

  assign isCrystal = (oscMode == clk_sel_pkg::OSC_LOW_POWER_CRYSTAL) ||
                     (oscMode == clk_sel_pkg::OSC_STANDARD_CRYSTAL) ||
                     (oscMode == clk_sel_pkg::OSC_HIGH_SPEED_CRYSTAL);
  assign timerDone = (timer_q == 16'(STARTUP_PERIODS));
  assign rcShift   = rcDivFor(freq_q);

  tick_divider #(.CW(8)) u_rcDiv (
    .clk     (clk),
    .reset_n (reset_n),
    .tickIn  (intRc8MhzTick),
    .shift   (rcShift),
    .tickOut (rcTick)
  );

  tick_divider #(.CW(8)) u_postDiv (
    .clk     (clk),
    .reset_n (reset_n),
    .tickIn  (pllTick),
    .shift   (post_q),
    .tickOut (pllSel)
  );

  // Straps are caught at the first clocked edge after reset release.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q      <= ST_STARTUP;
      strapTaken_q <= 1'b0;
    end else if (!strapTaken_q) begin
      strapTaken_q <= 1'b1;
      if (!isCrystal) begin
        state_q <= ST_RUN;
      end else begin
        state_q <= two_speed_start_enable ? ST_STARTUP : ST_WAITXT;
      end
    end else begin
      unique case (state_q)
        ST_STARTUP: if (timerDone) state_q <= ST_RUN;
        ST_WAITXT:  if (timerDone) state_q <= ST_RUN;
        ST_RUN:     state_q <= ST_RUN;
        default:    state_q <= ST_RUN;
      endcase
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      timer_q <= '0;
    end else if (strapTaken_q && isCrystal && primaryTick && !timerDone) begin
      timer_q <= timer_q + 16'h0001;
    end
  end

  // Software registers; a set of idle never hides a wake in the same cycle.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      freq_q <= clk_sel_pkg::FREQ_RESET;
      src_q  <= clk_sel_pkg::SRC_PRIMARY;
      pll_q  <= clk_sel_pkg::PLL_RESET;
      post_q <= clk_sel_pkg::POST_RESET;
    end else if (wr && paddr == clk_sel_pkg::OFS_CTRL) begin
      freq_q <= pwdata[clk_sel_pkg::CTRL_FREQ_LSB +: 3];
      src_q  <= pwdata[clk_sel_pkg::CTRL_SRC_LSB +: 2];
    end else if (wr && paddr == clk_sel_pkg::OFS_DIV) begin
      pll_q  <= pwdata[clk_sel_pkg::DIV_PLL_LSB +: 2];
      post_q <= pwdata[clk_sel_pkg::DIV_POST_LSB +: 3];
    end
  end

  // Idle flag: wake is checked first so a pending interrupt wins when periphIrqEn is set.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      idle_q <= 1'b0;
    end else if (periphIrq && periphIrqEn) begin
      idle_q <= 1'b0;
    end else if (wr && paddr == clk_sel_pkg::OFS_CTRL && pwdata[clk_sel_pkg::CTRL_IDLE]) begin
      idle_q <= 1'b1;
    end
  end

  // Selected system clock tick.
  always_comb begin
    if (state_q == ST_STARTUP) begin
      rawTick = rcTick;
    end else if (state_q == ST_WAITXT) begin
      rawTick = 1'b0;
    end else begin
      unique case (src_q)
        clk_sel_pkg::SRC_PRIMARY:  rawTick = primaryTick;
        clk_sel_pkg::SRC_INTERNAL: rawTick = rcTick;
        clk_sel_pkg::SRC_LOW_FREQ: rawTick = lowFreqTick;
        clk_sel_pkg::SRC_PLL:      rawTick = pllSel;
      endcase
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      phase_q <= '0;
    end else if (rawTick && !idle_q) begin
      phase_q <= phase_q + 2'h1;
    end
  end

  // Registered clock enables; peripherals keep the clock during idle.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sysClkTick    <= 1'b0;
      periphClkTick <= 1'b0;
      instrTick     <= 1'b0;
      coreRun       <= 1'b0;
    end else begin
      periphClkTick <= rawTick;
      sysClkTick    <= rawTick && !idle_q;
      instrTick     <= rawTick && !idle_q && (phase_q == 2'(clk_sel_pkg::PERIODS_PER_INSTR - 1));
      coreRun       <= !idle_q && (state_q != ST_WAITXT) && strapTaken_q;
    end
  end

  // Read data register, loaded in the setup cycle of a read.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      prdata <= '0;
    end else if (rd) begin
      unique case (paddr)
        clk_sel_pkg::OFS_CTRL:   prdata <= {23'h0, idle_q, 2'h0, src_q, 1'b0, freq_q};
        clk_sel_pkg::OFS_STATUS: prdata <= {28'h0, isCrystal, timerDone, state_q};
        clk_sel_pkg::OFS_DIV:    prdata <= {25'h0, post_q, 2'h0, pll_q};
        clk_sel_pkg::OFS_TIMER:  prdata <= {16'h0, timer_q};
        default:                 prdata <= '0;
      endcase
    end
  end

  // PLL multiplier select drives no output; it is only read back.
  logic unusedPll;
  assign unusedPll = ^pll_q;
endmodule : clock_select

// File: bench/clock_select_monitor.sv
// Purpose: Port timing checks for clock_select.
// Assumes: Straps stay steady while reset_n is high.
// Notes:   Idle is tracked from APB writes; the core state is internal.
`timescale 1ns/100ps
module clock_select_monitor #(
  parameter int STARTUP_PERIODS = 8
) (
  // Clock and reset
  input wire logic        clk,
  input wire logic        reset_n,
  // APB
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Straps, ticks and wake
  input wire logic        two_speed_start_enable,
  input wire logic [2:0]  oscMode,
  input wire logic        primaryTick,
  input wire logic        periphIrq,
  input wire logic        periphIrqEn,
  // Enables out
  input wire logic        sysClkTick,
  input wire logic        instrTick,
  input wire logic        coreRun
);
  logic [1:0] tickCnt_q;
  logic [7:0] cycCnt_q;
  logic [7:0] primCnt_q;
  logic       idleMon_q;
  logic       idleWr;
  logic       wake;

  // Idle request and wake as seen on the ports.
  assign idleWr = psel && penable && pwrite && paddr == clk_sel_pkg::OFS_CTRL && pwdata[8];
  assign wake   = periphIrq && periphIrqEn;

  // Cycle and primary-tick counters saturate, so a long run never wraps back into a start-up window.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cycCnt_q  <= 8'h00;
      primCnt_q <= 8'h00;
      tickCnt_q <= 2'h0;
      idleMon_q <= 1'b0;
    end else begin
      cycCnt_q  <= cycCnt_q + {7'h0, cycCnt_q != 8'hff};
      primCnt_q <= primCnt_q + {7'h0, primaryTick && primCnt_q != 8'hff};
      tickCnt_q <= instrTick ? 2'h0 : tickCnt_q + {1'b0, sysClkTick};
      idleMon_q <= wake ? 1'b0 : (idleWr ? 1'b1 : idleMon_q);
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  sequence idleEntry;
    idleWr && !wake;
  endsequence
  sequence groupEnd;
    sysClkTick && tickCnt_q == 2'h3;
  endsequence

  AST_INSTR_FOUR: assert property (instrTick |-> groupEnd)
    else $error("instruction tick off the fourth clock tick");
  AST_INSTR_DUE: assert property (groupEnd |-> instrTick)
    else $error("fourth clock tick gave no instruction tick");
  AST_BOOT_RUN: assert property (cycCnt_q == 8'h06 && (two_speed_start_enable
    || oscMode > 3'h2) |-> coreRun)
    else $error("core not running early in start-up");
  AST_XTAL_WAIT: assert property (!two_speed_start_enable && oscMode <= 3'h2
    && primCnt_q < STARTUP_PERIODS - 1 |-> !coreRun)
    else $error("core ran before crystal timer");
  AST_IDLE_ENTER: assert property (idleEntry |-> ##2 !coreRun)
    else $error("idle write did not stop core");
  AST_IDLE_QUIET: assert property (idleMon_q && !coreRun |-> !sysClkTick && !instrTick)
    else $error("core clock ticking in idle");
  AST_WAKE: assert property (idleMon_q && wake |-> ##[1:3] coreRun)
    else $error("interrupt did not end idle");
  AST_APB_OK: assert property (psel |-> pready && !pslverr)
    else $error("register access stalled or refused");
endmodule : clock_select_monitor

bind clock_select clock_select_monitor #(.STARTUP_PERIODS(STARTUP_PERIODS)) i_mon (
  .clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
  .two_speed_start_enable(two_speed_start_enable), .oscMode(oscMode),
  .primaryTick(primaryTick), .periphIrq(periphIrq), .periphIrqEn(periphIrqEn),
  .sysClkTick(sysClkTick), .instrTick(instrTick), .coreRun(coreRun));

// File: bench/two_speed_startup_clock_select_bench.sv
// Purpose: Self-checking bench for clock_select.
// Assumes: Oscillator ticks are made here at fixed rates, except the random PLL tick.
// Notes:   The crystal timer is cut to 8 periods to keep runs short.
`timescale 1ns/100ps
module two_speed_startup_clock_select_bench;
  localparam logic [7:0] CT = clk_sel_pkg::OFS_CTRL;
  localparam logic [7:0] ST = clk_sel_pkg::OFS_STATUS;
  localparam logic [7:0] DV = clk_sel_pkg::OFS_DIV;
  logic        clk = 1'b0;
  logic        reset_n = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata, r, d;
  logic        pready, pslverr, sysClkTick, periphClkTick, instrTick, coreRun;
  logic        strap = 1'b0;
  logic [2:0]  oscMode = 3'h0;
  logic [3:0]  ticks = 4'h0;
  logic        irq = 1'b0;
  logic        irqEn = 1'b0;
  logic [2:0]  codes [3] = '{clk_sel_pkg::FREQ_1MHZ, clk_sel_pkg::FREQ_4MHZ,
                             clk_sel_pkg::FREQ_8MHZ};
  int          cyc = 0;
  int          s, i, p, q, e;
  int          mismatches = 0;
  int          total_checks = 0;

  always #25 clk = ~clk;

  // Ticks at unrelated rates; the PLL tick is random to shake out phase slips.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    ticks <= {1'($urandom_range(1)), cyc % 7 == 0, cyc[0], cyc % 3 == 0};
  end

  clock_select #(.STARTUP_PERIODS(8)) i_dut (.clk(clk), .reset_n(reset_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .two_speed_start_enable(strap), .oscMode(oscMode),
    .primaryTick(ticks[0]), .intRc8MhzTick(ticks[1]), .lowFreqTick(ticks[2]),
    .pllTick(ticks[3]), .periphIrq(irq), .periphIrqEn(irqEn), .sysClkTick(sysClkTick),
    .periphClkTick(periphClkTick), .instrTick(instrTick), .coreRun(coreRun));

  // Expected system ticks in 160 cycles with the RC ticking every second cycle.
  function automatic int rate(input logic [2:0] c);
    return c == clk_sel_pkg::FREQ_8MHZ ? 80 : (c == clk_sel_pkg::FREQ_4MHZ ? 40 : 10);
  endfunction : rate

  // Expected system ticks in 160 cycles per run-time source; n is the PLL ticks seen.
  function automatic int srcRate(input logic [1:0] c, input logic [2:0] ps, input int n);
    case (c)
      clk_sel_pkg::SRC_PRIMARY:  return 53;
      clk_sel_pkg::SRC_INTERNAL: return 80;
      clk_sel_pkg::SRC_LOW_FREQ: return 23;
      default:                   return n >> ps;
    endcase
  endfunction : srcRate

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  // Read data is taken at the edge where pready is seen high; one idle cycle follows.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] v);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= v;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    r = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb

  task automatic count();
    s = 0;
    i = 0;
    p = 0;
    q = 0;
    repeat (160) begin
      @(posedge clk);
      s += int'(sysClkTick);
      i += int'(instrTick);
      p += int'(periphClkTick);
      q += int'(ticks[3]);
    end
  endtask : count

  task automatic close_out();
    $display("Checks %0d, mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : close_out

  initial begin
    #2_000_000;
    mismatches++;
    close_out();
  end

  initial begin
    void'($urandom(9));
    for (int m = 0; m < 10; m++) begin
      reset_n <= 1'b0;
      strap <= 1'(m % 2);
      oscMode <= 3'(m / 2);
      repeat (6) @(posedge clk);
      reset_n <= 1'b1;
      repeat (8) @(posedge clk);
      check(32'(coreRun), 32'(strap || oscMode > 3'h2));
      apb(1'b0, ST, 32'h0);
      check(32'(r[3]), 32'(oscMode < 3'h3));
      for (int k = 0; k < 40 && r[1:0] !== 2'h2; k++) apb(1'b0, ST, 32'h0);
      check({30'h0, r[1:0]}, 32'h2);
      repeat (2) @(posedge clk);
      check(32'(coreRun), 32'h1);
    end
    $display("Test boot done");
    foreach (codes[k]) begin
      apb(1'b1, CT, {26'h0, clk_sel_pkg::SRC_INTERNAL, 1'b0, codes[k]});
      apb(1'b0, CT, 32'h0);
      check({26'h0, r[5:0]}, {26'h0, clk_sel_pkg::SRC_INTERNAL, 1'b0, codes[k]});
      count();
      check(32'(s >= rate(codes[k]) - 2 && s <= rate(codes[k]) + 2), 32'h1);
      check(32'(i >= s / 4 - 1 && i <= s / 4 + 1), 32'h1);
    end
    $display("Test frequency done");
    repeat (4) begin
      d = $urandom;
      apb(1'b1, CT, {26'h0, d[5:4], 4'h7});
      apb(1'b1, DV, {25'h0, d[10:8], 2'h0, d[1:0]});
      apb(1'b0, CT, 32'h0);
      check({26'h0, r[5:0]}, {26'h0, d[5:4], 4'h7});
      apb(1'b0, DV, 32'h0);
      check({25'h0, r[6:0]}, {25'h0, d[10:8], 2'h0, d[1:0]});
      check(32'(coreRun), 32'h1);
      count();
      e = srcRate(d[5:4], d[10:8], q);
      check(32'(s >= e - 2 && s <= e + 2), 32'h1);
    end
    apb(1'b0, 8'h10, 32'h0);
    check(r, 32'h0);
    $display("Test switching done");
    apb(1'b1, DV, 32'h0);
    apb(1'b1, CT, 32'h0000_0117);
    apb(1'b0, CT, 32'h0);
    check({31'h0, r[8]}, 32'h1);
    irq <= 1'b1;
    count();
    check(32'(p > 0 && s == 0 && coreRun === 1'b0), 32'h1);
    irqEn <= 1'b1;
    repeat (4) @(posedge clk);
    check(32'(coreRun), 32'h1);
    apb(1'b0, CT, 32'h0);
    check({31'h0, r[8]}, 32'h0);
    $display("Test idle done");
    close_out();
  end
endmodule : two_speed_startup_clock_select_bench
